// ===== mcu_model.sv
// behavioural controller on the far side of the serial data port
`timescale 1ns/1ps
module mcu_model (
    input  logic dclk,
    input  logic dclk_oe,
    input  logic rx_pin,
    input  logic free_bit,
    output logic tx_pin,
    output logic rx_seen
);
    logic sync_bit = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // all controller actions sit on the falling data clock
    always @(negedge dclk) begin
        if (dclk_oe) begin
            sync_bit <= 1'($urandom);
            rx_seen  <= rx_pin;
        end
    end
    // no data clock in transparent mode, the bench steers the bit directly
    assign tx_pin = dclk_oe ? sync_bit : free_bit;
endmodule // mcu_model

// ===== rate_divider.sv
// reference divider times power-of-two shift, one-cycle enable output
`timescale 1ns/1ps
`include "xcvr_consts.svh"
module rate_divider (
    input  wire logic       CLK,
    input  wire logic       RESET,
    input  wire logic       run,
    input  wire logic [5:0] ref_div,
    input  wire logic [2:0] shift,
    output logic            tick
);
    logic [5:0]  ref_cnt_reg;
    logic [6:0]  pow_cnt_reg;
    logic [5:0]  ref_eff;
    logic [6:0]  pow_top;
    logic        ref_tick;

    // a zero divider is treated as one so the chain never stalls
    assign ref_eff  = (ref_div == 6'h00) ? `DIV_MIN : ref_div;
    assign pow_top  = 7'(({1'b0, 7'h7F} >> shift) >> 1); // 2^(6-shift) - 1
    assign ref_tick = (ref_cnt_reg == ref_eff - `DIV_MIN);

    // first stage divides by the reference value
    always_ff @(posedge CLK) begin
        if (RESET || !run) begin
            ref_cnt_reg <= 6'h00;
        end else if (ref_tick) begin
            ref_cnt_reg <= 6'h00;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 6'h01;
        end
    end

    // second stage divides by two to the power of six minus shift: each tick is
    // half a bit-rate period, so a toggle per tick gives the full programmed rate
    always_ff @(posedge CLK) begin
        if (RESET || !run) begin
            pow_cnt_reg <= 7'h00;
            tick        <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (ref_tick) begin
                if (pow_cnt_reg >= pow_top) begin
                    pow_cnt_reg <= 7'h00;
                    tick        <= 1'b1;
                end else begin
                    pow_cnt_reg <= pow_cnt_reg + 7'h01;
                end
            end
        end
    end
endmodule // rate_divider

// ===== tb_xcvr_mode_port.sv
// self-checking bench for the transceiver mode and data port
`timescale 1ns/1ps
module tb_xcvr_mode_port;
    logic       CLK = 1'b0, RESET = 1'b1, PROG_SELECT = 1'b0, PROG_SCLK = 1'b0;
    logic       I_LAGS_Q = 1'b0, io_drv = 1'b0, free_bit = 1'b0, mcu_tx, rx_seen;
    wire        PROG_IO_IN, SERIAL_DATA_PIN_IN;
    logic       PROG_IO_OUT, PROG_IO_OE, SERIAL_DATA_PIN_OUT, SERIAL_DATA_PIN_OE;
    logic       DATA_CLOCK_PIN_OUT, DATA_CLOCK_PIN_OE, TX_BIT, TX_BIT_STROBE, XCO_RUN;
    logic       RX_ENABLE, TX_ENABLE, LOW_NOISE_AMP_BYPASS, SIGNAL_STRENGTH_ENABLE;
    logic       LOCK_DETECT_ENABLE, RESYNC_ENABLE;
    logic [1:0] OP_STATE, PREFILTER_CUTOFF;
    logic [2:0] AMP_LEVEL;
    int         errors = 0, total_checks = 0;

    // shared wires: whoever enables its driver sets the level
    assign PROG_IO_IN         = PROG_IO_OE ? PROG_IO_OUT : io_drv;
    assign SERIAL_DATA_PIN_IN = SERIAL_DATA_PIN_OE ? SERIAL_DATA_PIN_OUT : mcu_tx;

    xcvr_mode_port DUT (.*);
    mcu_model MCU (.dclk(DATA_CLOCK_PIN_OUT), .dclk_oe(DATA_CLOCK_PIN_OE), .rx_pin(SERIAL_DATA_PIN_IN),
        .free_bit(free_bit), .tx_pin(mcu_tx), .rx_seen(rx_seen));

    // 40 MHz system clock
    initial begin
        forever #12.5 CLK = ~CLK;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // expected data clock half period in system cycles: half of divider times 2^(7-s)
    function automatic int half(input logic [5:0] d, input logic [2:0] s);
        return int'(d == 6'h00 ? 6'h01 : d) << (6 - (s == 3'h7 ? 6 : int'(s)));
    endfunction

    // one programming bit; six cycles per phase leaves room for the synchronisers
    task automatic bit_x(input logic b, output logic q);
        io_drv    = b;
        PROG_SCLK = 1'b1;
        repeat (6) @(negedge CLK);
        q         = PROG_IO_IN;
        PROG_SCLK = 1'b0;
        repeat (6) @(negedge CLK);
    endtask

    task automatic acc(input logic [6:0] a, input logic rw, inout logic [7:0] d);
        logic       q;
        logic [1:0] st;
        st          = OP_STATE;
        PROG_SELECT = 1'b1;
        @(negedge CLK);
        for (int i = 6; i >= 0; i--) bit_x(a[i], q);
        bit_x(rw, q);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q);
            d[i] = q;
        end
        chk(OP_STATE, st);
        PROG_SELECT = 1'b0;
        repeat (8) @(negedge CLK);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        acc(a, 1'b0, v);
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        v = 8'h00;
        acc(a, 1'b1, v);
    endtask

    // length of one high phase of the data clock
    task automatic meas(output int n);
        n = 0;
        while (DATA_CLOCK_PIN_OUT !== 1'b0) @(negedge CLK);
        while (DATA_CLOCK_PIN_OUT !== 1'b1) @(negedge CLK);
        while (DATA_CLOCK_PIN_OUT === 1'b1) begin
            n++;
            @(negedge CLK);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog sized well above the expected run
    initial begin
        repeat (90000) @(negedge CLK);
        errors++;
        final_report;
    end

    initial begin
        static logic [6:0] ad [5] = '{7'h00, 7'h01, 7'h06, 7'h07, 7'h05};
        static logic [7:0] ex [5] = '{8'h01, 8'h80, 8'h00, 8'h01, 8'h00};
        static logic [5:0] dv [6] = '{6'h03, 6'h05, 6'h00, 6'h01, 6'h3F, 6'h02};
        static logic [2:0] sh [6] = '{3'h6, 3'h5, 3'h7, 3'h3, 3'h6, 3'h7};
        logic [7:0] v, r;
        logic [1:0] s;
        logic       b;
        int         n;
        void'($urandom(77594));
        repeat (12) @(negedge CLK);
        RESET = 1'b0;
        @(negedge CLK);
        // reset contents, last one unmapped
        for (int i = 0; i < 5; i++) begin
            rd(ad[i], r);
            chk(r, ex[i]);
        end
        // every state twice, random front end and amplifier bits
        for (int i = 0; i < 8; i++) begin
            v      = 8'($urandom);
            v[3:0] = {1'b0, 2'(i), 1'b1};
            s      = v[2:1];
            wr(7'h00, v);
            rd(7'h00, r);
            chk(r, v);
            chk({XCO_RUN, RX_ENABLE, TX_ENABLE, DATA_CLOCK_PIN_OE, SERIAL_DATA_PIN_OE, OP_STATE},
                {s != 2'h0, s == 2'h2, s == 2'h3, 1'b0, s == 2'h2, s});
            chk(LOW_NOISE_AMP_BYPASS, v[7]);
            chk(AMP_LEVEL, s == 2'h3 ? v[6:4] : 3'h0);
        end
        for (int i = 0; i < 4; i++) begin
            v      = 8'($urandom);
            v[1:0] = 2'(i);
            wr(7'h01, v);
            chk({SIGNAL_STRENGTH_ENABLE, LOCK_DETECT_ENABLE, PREFILTER_CUTOFF}, v[3:0]);
        end
        // transparent receive then transparent transmit
        wr(7'h00, 8'h05);
        for (int i = 0; i < 8; i++) begin
            I_LAGS_Q = 1'($urandom);
            repeat (6) @(negedge CLK);
            chk(SERIAL_DATA_PIN_OUT, I_LAGS_Q);
        end
        wr(7'h00, 8'h07);
        for (int i = 0; i < 8; i++) begin
            free_bit = 1'($urandom);
            repeat (6) @(negedge CLK);
            chk(TX_BIT, free_bit);
        end
        // synchronous transmit over divider and shift corners
        for (int i = 0; i < 6; i++) begin
            wr(7'h07, {sh[i][1:0], dv[i]});
            wr(7'h06, {4'h0, 3'h6, sh[i][2]});
            wr(7'h00, 8'h0F);
            chk(DATA_CLOCK_PIN_OE, 1'b1);
            meas(n);
            chk(8'(n), 8'(half(dv[i], sh[i])));
            // phases shorter than six cycles are too short for the pin synchroniser
            if (n >= 6) begin
                for (int k = 0; k < 4; k++) begin
                    while (TX_BIT_STROBE !== 1'b1) @(negedge CLK);
                    b = mcu_tx;
                    repeat (2) @(negedge CLK);
                    chk(TX_BIT, b);
                end
            end
        end
        // synchronous receive, sixteen resync ticks per bit
        wr(7'h07, 8'h01);
        wr(7'h00, 8'h0D);
        chk({DATA_CLOCK_PIN_OE, RESYNC_ENABLE}, 2'h3);
        meas(n);
        // high phase is eight resync clocks of two half periods each
        chk(8'(n), 8'(16 * half(6'h01, 3'h6)));
        for (int i = 0; i < 4; i++) begin
            I_LAGS_Q = 1'($urandom);
            repeat (120) @(negedge CLK);
            chk(rx_seen, I_LAGS_Q);
        end
        // second reset in mid-run
        RESET = 1'b1;
        repeat (2) @(negedge CLK);
        RESET = 1'b0;
        @(negedge CLK);
        chk(OP_STATE, 2'h0);
        rd(7'h06, r);
        chk(r, 8'h00);
        final_report;
    end
endmodule // tb_xcvr_mode_port

// ===== xcvr_consts.svh
// constants for the transceiver mode and data port
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH
`define ADDR_OP_CTRL      7'h00
`define ADDR_RX_FILT      7'h01
`define ADDR_CLK_SHIFT    7'h06
`define ADDR_RATE_DIV     7'h07
`define OPC_BYPASS_BIT    7
`define OPC_AMP_HI        6
`define OPC_AMP_LO        4
`define OPC_SYNC_BIT      3
`define OPC_STATE_HI      2
`define OPC_STATE_LO      1
`define OPC_RESET         8'h01
`define RXF_RESET         8'h80
`define CLKS_RESET        8'h00
`define RATE_RESET        8'h01
`define SHIFT_TOP         3'h7
`define SHIFT_MAX_RATE    3'h6
`define DIV_MIN           6'h01
`define BITS_PER_WORD     4'h8
`define ADDR_BITS         4'h7
`define RESYNC_OVERSAMPLE 5'h10
`endif

// ===== xcvr_mode_port.sv
// operating-state control registers, three-wire access and serial data port
// Functional notes
// - state field 00 power down, 01 standby, 10 receive, 11 transmit.
// - sync mode in receive runs resync and drives recovered clock on data clock.
// - sync off passes data transparently, no clock driven.
// - sync transmit drives programmed bit-rate clock on data clock pin.
// - sync transmit captures data pin on each rising data clock edge.
// - rate clock is crystal divided by divider times 2^(7-shift).
// - reference divider is six bits, values 1 to 63.
// - rate shift is three bits, usable 0 to 6.
// - in sync mode device is master and supplies the data clock.
// - sync receive updates bit on rising edge, controller samples falling.
// - data one when I lags Q, zero when I leads Q.
// - bypass bit one routes input around amplifier, zero keeps it.
// - cutoff field selects 100, 150, 230 or 340 kHz.
// - written values take effect only when select goes low.
`timescale 1ns/1ps
`include "xcvr_consts.svh"
module xcvr_mode_port (
    input  wire logic       CLK,
    input  wire logic       RESET,
    // three-wire programming pins
    input  wire logic       PROG_SELECT,
    input  wire logic       PROG_SCLK,
    input  wire logic       PROG_IO_IN,
    output logic            PROG_IO_OUT,
    output logic            PROG_IO_OE,
    // demodulator phase inputs
    input  wire logic       I_LAGS_Q,
    // serial data port
    input  wire logic       SERIAL_DATA_PIN_IN,
    output logic            SERIAL_DATA_PIN_OUT,
    output logic            SERIAL_DATA_PIN_OE,
    output logic            DATA_CLOCK_PIN_OUT,
    output logic            DATA_CLOCK_PIN_OE,
    // transmit bit toward the modulator
    output logic            TX_BIT,
    output logic            TX_BIT_STROBE,
    // analog control outputs
    output logic [1:0]      OP_STATE,
    output logic            XCO_RUN,
    output logic            RX_ENABLE,
    output logic            TX_ENABLE,
    output logic            LOW_NOISE_AMP_BYPASS,
    output logic [2:0]      AMP_LEVEL,
    output logic [1:0]      PREFILTER_CUTOFF,
    output logic            SIGNAL_STRENGTH_ENABLE,
    output logic            LOCK_DETECT_ENABLE,
    output logic            RESYNC_ENABLE
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] sel_sync_reg;
    logic [1:0] sclk_sync_reg;
    logic [1:0] io_sync_reg;
    logic [1:0] lag_sync_reg;
    logic [1:0] dat_sync_reg;
    logic       sel_d_reg;
    logic       sclk_d_reg;

    // two flops on every pin; the second stage is read, plus a third flop on select and clock for edge detection
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sel_sync_reg  <= 2'h0;
            sclk_sync_reg <= 2'h0;
            io_sync_reg   <= 2'h0;
            lag_sync_reg  <= 2'h0;
            dat_sync_reg  <= 2'h0;
            sel_d_reg     <= 1'b0;
            sclk_d_reg    <= 1'b0;
        end else begin
            sel_sync_reg  <= {sel_sync_reg[0], PROG_SELECT};
            sclk_sync_reg <= {sclk_sync_reg[0], PROG_SCLK};
            io_sync_reg   <= {io_sync_reg[0], PROG_IO_IN};
            lag_sync_reg  <= {lag_sync_reg[0], I_LAGS_Q};
            dat_sync_reg  <= {dat_sync_reg[0], SERIAL_DATA_PIN_IN};
            sel_d_reg     <= sel_sync_reg[1];
            sclk_d_reg    <= sclk_sync_reg[1];
        end
    end

    logic sel;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_fall;
    assign sel       = sel_sync_reg[1];
    assign sclk_rise = sel && sclk_sync_reg[1] && !sclk_d_reg;
    assign sclk_fall = sel && !sclk_sync_reg[1] && sclk_d_reg;
    assign sel_fall  = !sel && sel_d_reg;

    ////////////////////////////////////////////////////////////////////////////
    // shadow registers written over the serial programming port
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [6:0] addr_reg;
    logic       read_reg;
    logic       hdr_done_reg;
    logic [7:0] sh_opc_reg;
    logic [7:0] sh_rxf_reg;
    logic [7:0] sh_clks_reg;
    logic [7:0] sh_rate_reg;

    function automatic logic [7:0] reg_pick(input logic [6:0] a, input logic [7:0] o,
                                           input logic [7:0] r, input logic [7:0] c,
                                           input logic [7:0] d);
        case (a)
            `ADDR_OP_CTRL:   reg_pick = o;
            `ADDR_RX_FILT:   reg_pick = r;
            `ADDR_CLK_SHIFT: reg_pick = c;
            `ADDR_RATE_DIV:  reg_pick = d;
            default:         reg_pick = 8'h00;
        endcase
    endfunction

    // shift in header then data octets; address increments per octet
    always_ff @(posedge CLK) begin
        if (RESET || !sel) begin
            shift_reg    <= 8'h00;
            bit_cnt_reg  <= 4'h0;
            addr_reg     <= 7'h00;
            read_reg     <= 1'b0;
            hdr_done_reg <= 1'b0;
        end else if (sclk_fall && !(hdr_done_reg && read_reg)) begin
            if (bit_cnt_reg == `BITS_PER_WORD - 4'h1) begin
                bit_cnt_reg <= 4'h0;
                if (!hdr_done_reg) begin
                    addr_reg     <= shift_reg[6:0];
                    read_reg     <= io_sync_reg[1];
                    hdr_done_reg <= 1'b1;
                    if (io_sync_reg[1]) begin
                        shift_reg <= reg_pick(shift_reg[6:0], sh_opc_reg, sh_rxf_reg,
                                              sh_clks_reg, sh_rate_reg);
                    end
                end else begin
                    addr_reg <= addr_reg + 7'h01;
                end
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                shift_reg   <= {shift_reg[6:0], io_sync_reg[1]};
            end
        end else if (sclk_rise && hdr_done_reg && read_reg) begin
            // read data leaves msb first on rising edges; each octet is fetched
            // at its own first rise so the msb is not shifted away unseen
            if (bit_cnt_reg == 4'h0) begin
                shift_reg <= reg_pick(addr_reg, sh_opc_reg, sh_rxf_reg,
                                      sh_clks_reg, sh_rate_reg);
            end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
            end
            if (bit_cnt_reg == `BITS_PER_WORD - 4'h1) begin
                bit_cnt_reg <= 4'h0;
                addr_reg    <= addr_reg + 7'h01;
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    logic write_octet;
    logic [7:0] write_val;
    assign write_octet = sclk_fall && hdr_done_reg && !read_reg &&
                         (bit_cnt_reg == `BITS_PER_WORD - 4'h1);
    assign write_val   = {shift_reg[6:0], io_sync_reg[1]};

    // shadow copies hold written octets until select drops
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sh_opc_reg  <= `OPC_RESET;
            sh_rxf_reg  <= `RXF_RESET;
            sh_clks_reg <= `CLKS_RESET;
            sh_rate_reg <= `RATE_RESET;
        end else if (write_octet) begin
            if (addr_reg == `ADDR_OP_CTRL)   sh_opc_reg  <= write_val;
            if (addr_reg == `ADDR_RX_FILT)   sh_rxf_reg  <= write_val;
            if (addr_reg == `ADDR_CLK_SHIFT) sh_clks_reg <= write_val;
            if (addr_reg == `ADDR_RATE_DIV)  sh_rate_reg <= write_val;
        end
    end

    assign PROG_IO_OE  = sel && hdr_done_reg && read_reg;
    assign PROG_IO_OUT = shift_reg[7];

    ////////////////////////////////////////////////////////////////////////////
    // active registers, loaded when select falls
    logic [7:0] opc_reg;
    logic [7:0] rxf_reg;
    logic [7:0] clks_reg;
    logic [7:0] rate_reg;

    // loading on select low keeps a half-written set from reaching the radio
    always_ff @(posedge CLK) begin
        if (RESET) begin
            opc_reg  <= `OPC_RESET;
            rxf_reg  <= `RXF_RESET;
            clks_reg <= `CLKS_RESET;
            rate_reg <= `RATE_RESET;
        end else if (sel_fall) begin
            opc_reg  <= sh_opc_reg;
            rxf_reg  <= sh_rxf_reg;
            clks_reg <= sh_clks_reg;
            rate_reg <= sh_rate_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded controls
    xcvr_pkg::op_state_e state;
    logic       sync_en;
    logic       in_tx;
    logic       in_rx;
    logic [5:0] ref_div;
    logic [2:0] rate_shift;
    logic [2:0] resync_shift;

    assign state        = xcvr_pkg::op_state_e'(opc_reg[`OPC_STATE_HI:`OPC_STATE_LO]);
    assign sync_en      = opc_reg[`OPC_SYNC_BIT];
    assign in_tx        = (state == xcvr_pkg::ST_TRANSMIT);
    assign in_rx        = (state == xcvr_pkg::ST_RECEIVE);
    assign ref_div      = rate_reg[5:0];
    assign rate_shift   = {clks_reg[0], rate_reg[7:6]};
    assign resync_shift = clks_reg[3:1];

    // power state decode; power down keeps all registers
    always_comb begin
        XCO_RUN   = 1'b1;
        RX_ENABLE = 1'b0;
        TX_ENABLE = 1'b0;
        unique case (state)
            xcvr_pkg::ST_POWER_DOWN: XCO_RUN = 1'b0;
            xcvr_pkg::ST_STANDBY:    XCO_RUN = 1'b1;
            xcvr_pkg::ST_RECEIVE:    RX_ENABLE = 1'b1;
            xcvr_pkg::ST_TRANSMIT:   TX_ENABLE = 1'b1;
        endcase
    end

    assign OP_STATE               = opc_reg[`OPC_STATE_HI:`OPC_STATE_LO];
    assign LOW_NOISE_AMP_BYPASS   = opc_reg[`OPC_BYPASS_BIT];
    assign AMP_LEVEL              = in_tx ? opc_reg[`OPC_AMP_HI:`OPC_AMP_LO] : 3'h0;
    assign PREFILTER_CUTOFF       = rxf_reg[1:0];
    assign LOCK_DETECT_ENABLE     = rxf_reg[2];
    assign SIGNAL_STRENGTH_ENABLE = rxf_reg[3];
    assign RESYNC_ENABLE          = sync_en && in_rx;

    ////////////////////////////////////////////////////////////////////////////
    // clock dividers: bit-rate for transmit, oversampling for receive
    logic       rate_tick;
    logic       resync_tick;
    logic [2:0] rate_shift_eff;

    // a shift of seven exceeds the usable range and is held at six
    assign rate_shift_eff = (rate_shift == `SHIFT_TOP) ? `SHIFT_MAX_RATE : rate_shift;

    rate_divider u_rate_div (
        .CLK   (CLK),
        .RESET (RESET),
        .run   (sync_en && in_tx),
        .ref_div (ref_div),
        .shift (rate_shift_eff),
        .tick  (rate_tick)
    );

    rate_divider u_resync_div (
        .CLK   (CLK),
        .RESET (RESET),
        .run   (RESYNC_ENABLE),
        .ref_div (ref_div),
        .shift (resync_shift),
        .tick  (resync_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // data port
    logic       dclk_reg;
    logic [3:0] phase_reg;
    logic       resync_half_reg;
    logic       rx_bit_reg;
    logic       demod;

    assign demod = lag_sync_reg[1];

    // data clock toggles; one full period per bit in transmit,
    // sixteen resync ticks per bit in receive
    always_ff @(posedge CLK) begin
        if (RESET || !sync_en || !(in_tx || in_rx)) begin
            dclk_reg        <= 1'b0;
            phase_reg       <= 4'h0;
            resync_half_reg <= 1'b0;
            rx_bit_reg      <= 1'b0;
        end else if (in_tx && rate_tick) begin
            dclk_reg <= !dclk_reg;
        end else if (in_rx && resync_tick) begin
            // divider ticks come at twice the resync rate, so every second counts
            resync_half_reg <= !resync_half_reg;
            if (resync_half_reg) begin
                phase_reg <= phase_reg + 4'h1;
                if (phase_reg == 4'h7) begin
                    dclk_reg <= 1'b0; // falling edge, controller samples
                end
                if (phase_reg == 4'hF) begin
                    dclk_reg   <= 1'b1;
                    rx_bit_reg <= demod;
                end
            end
        end
    end

    // transmit bit captured on the rising edge this block drives
    always_ff @(posedge CLK) begin
        if (RESET) begin
            TX_BIT        <= 1'b0;
            TX_BIT_STROBE <= 1'b0;
        end else begin
            TX_BIT_STROBE <= 1'b0;
            if (in_tx && !sync_en) begin
                TX_BIT <= dat_sync_reg[1];
            end else if (in_tx && rate_tick && !dclk_reg) begin
                TX_BIT        <= dat_sync_reg[1];
                TX_BIT_STROBE <= 1'b1;
            end
        end
    end

    // the controller never drives the data clock in sync mode
    assign DATA_CLOCK_PIN_OE   = sync_en && (in_tx || in_rx);
    assign DATA_CLOCK_PIN_OUT  = dclk_reg;
    assign SERIAL_DATA_PIN_OE  = in_rx;
    assign SERIAL_DATA_PIN_OUT = sync_en ? rx_bit_reg : demod;
endmodule // xcvr_mode_port

// ===== xcvr_mode_port_assertions.sv
// concurrent checks on the pins of the transceiver mode and data port
`timescale 1ns/1ps
module xcvr_mode_port_chk (
    input logic       CLK,
    input logic       RESET,
    input logic       PROG_SELECT,
    input logic [1:0] OP_STATE,
    input logic       XCO_RUN,
    input logic       RX_ENABLE,
    input logic       TX_ENABLE,
    input logic [2:0] AMP_LEVEL,
    input logic       LOW_NOISE_AMP_BYPASS,
    input logic       SERIAL_DATA_PIN_OUT,
    input logic       SERIAL_DATA_PIN_OE,
    input logic       DATA_CLOCK_PIN_OUT,
    input logic       DATA_CLOCK_PIN_OE,
    input logic       TX_BIT,
    input logic       TX_BIT_STROBE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    ////////////////////////////////////////////////////////////////////////////
    // state field against the decoded enables
    AST_STATE_DECODE: assert property ({RX_ENABLE, TX_ENABLE} == {OP_STATE == 2'h2, OP_STATE == 2'h3})
        else $error("state decode wrong");
    AST_XCO_RUN: assert property (XCO_RUN == (OP_STATE != 2'h0))
        else $error("oscillator enable wrong");
    AST_CLOCK_IDLE: assert property (!(RX_ENABLE || TX_ENABLE) |-> !DATA_CLOCK_PIN_OE)
        else $error("data clock driven while idle");
    AST_RX_DATA_OE: assert property (SERIAL_DATA_PIN_OE == RX_ENABLE)
        else $error("data pin drive wrong");
    AST_AMP_OFF: assert property (!TX_ENABLE |-> AMP_LEVEL == 3'h0)
        else $error("amplifier level outside transmit");

    ////////////////////////////////////////////////////////////////////////////
    // synchronous transmit: capture strobe bound to the rising data clock
    AST_STROBE_ON_RISE: assert property (TX_BIT_STROBE |-> $rose(DATA_CLOCK_PIN_OUT) && TX_ENABLE)
        else $error("strobe without rising data clock");
    AST_RISE_STROBES: assert property ($rose(DATA_CLOCK_PIN_OUT) && TX_ENABLE && DATA_CLOCK_PIN_OE
        && $past(TX_ENABLE && DATA_CLOCK_PIN_OE) |-> TX_BIT_STROBE)
        else $error("rising data clock without strobe");
    // shortest period is two system cycles, one per half
    AST_STROBE_SPACING: assert property (TX_BIT_STROBE |=> !TX_BIT_STROBE)
        else $error("strobes too close");
    AST_TX_BIT_HOLD: assert property (TX_ENABLE && DATA_CLOCK_PIN_OE
        && $past(TX_ENABLE && DATA_CLOCK_PIN_OE, 2) && !TX_BIT_STROBE && !$past(TX_BIT_STROBE)
        |-> $stable(TX_BIT))
        else $error("transmit bit moved between captures");
    // synchronous receive: new bit only with the rising data clock
    AST_RX_UPDATE_ON_RISE: assert property (RX_ENABLE && DATA_CLOCK_PIN_OE
        && $past(RX_ENABLE && DATA_CLOCK_PIN_OE) && $changed(SERIAL_DATA_PIN_OUT)
        |-> $rose(DATA_CLOCK_PIN_OUT))
        else $error("receive bit moved off the rising edge");
    // registers only load after select falls, so a long low spell changes nothing
    AST_LOAD_ON_SELECT: assert property ((!PROG_SELECT) [*8] |=> $stable(OP_STATE)
        && $stable(LOW_NOISE_AMP_BYPASS))
        else $error("control changed without a load");
endmodule // xcvr_mode_port_chk

bind xcvr_mode_port xcvr_mode_port_chk chk (.*);

// ===== xcvr_pkg.sv
// shared types for the transceiver mode and data port
package xcvr_pkg;
    typedef enum logic [1:0] {
        ST_POWER_DOWN = 2'h0,
        ST_STANDBY    = 2'h1,
        ST_RECEIVE    = 2'h2,
        ST_TRANSMIT   = 2'h3
    } op_state_e;
    typedef enum logic [1:0] {
        CUT_100K = 2'h0,
        CUT_150K = 2'h1,
        CUT_230K = 2'h2,
        CUT_340K = 2'h3
    } cutoff_e;
endpackage
